// >>> common/radio_ctrl_pkg.sv
// Constants and types shared by the radio state controller, its assertions and its testbench
package radio_ctrl_pkg;

	// Transition and calibration times, in crystal cycles (CLK is the crystal clock)
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [15:0] IDLE_TO_RX_CYCLES = 16'h07A1;
	localparam logic [15:0] RX_TO_IDLE_CYCLES = 16'h0002;
	localparam logic [15:0] MANUAL_CAL_BASE_CYCLES = 16'h011B;
	localparam logic [15:0] CAL_NO_CP_SHORT_CYCLES = 16'h0EB4;
	localparam logic [15:0] CAL_NO_CP_LONG_CYCLES = 16'h0FE9;
	localparam logic [15:0] XOSC_START_CYCLES = 16'h0040;
	localparam int COUNT_W = 16;

	// Receive FIFO geometry
	localparam int RX_FIFO_DEPTH = 64;
	localparam int RX_FIFO_WIDTH = 8;
	localparam int RX_COUNT_W = 7;

	// Auto calibration choices
	localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
	localparam logic [1:0] AUTOCAL_IDLE_TO_RX = 2'h1;
	localparam logic [1:0] AUTOCAL_RX_TO_IDLE = 2'h2;
	localparam logic [1:0] AUTOCAL_EVERY_FOURTH = 2'h3;

	// Receive exit choices
	localparam logic [1:0] RXEXIT_IDLE = 2'h0;
	localparam logic [1:0] RXEXIT_STAY_RX = 2'h3;

	// Charge pump calibration disabled code, long-calibration test bit
	localparam logic [1:0] CP_CAL_OFF = 2'h0;
	localparam int TEST_LONG_CAL_BIT = 1;

	// Carrier absence under on-off keying counts after this many symbols
	localparam logic [3:0] OOK_MIN_SYMBOLS = 4'h8;

	// Status byte fields
	localparam int STATUS_READY_BIT = 7;
	localparam int STATUS_STATE_LSB = 4;
	localparam logic [3:0] STATUS_FILL_MAX = 4'hF;
	localparam logic [2:0] CODE_IDLE = 3'h0;
	localparam logic [2:0] CODE_RX = 3'h1;
	localparam logic [2:0] CODE_SETTLE = 3'h3;
	localparam logic [2:0] CODE_CAL = 3'h4;
	localparam logic [2:0] CODE_OVERFLOW = 3'h6;
	localparam logic [2:0] CODE_OFF = 3'h7;

	typedef enum logic [8:0] {
		ST_SLEEP = 9'h001,
		ST_CRYSTAL_OFF_STATE = 9'h002,
		ST_WAKE = 9'h004,
		ST_IDLE = 9'h008,
		ST_CAL = 9'h010,
		ST_SETTLE = 9'h020,
		ST_RX = 9'h040,
		ST_ENDCAL = 9'h080,
		ST_OVERFLOW = 9'h100
	} state_type;

endpackage

// >>> core/rx_byte_fifo.sv
// Flip-flop FIFO with valid/ready on both sides, flush and fill count
`timescale 1ns/10ps
module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic do_write;
	logic do_read;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = store[rd_ptr];
	assign do_write = in_valid && in_ready;
	assign do_read = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (clk_en && do_write) begin
			store[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				count <= '0;
			end else begin
				if (do_write) begin
					wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
				end
				if (do_read) begin
					rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
				end
				// Simultaneous write and read keeps the count steady
				if (do_write && !do_read) begin
					count <= count + 1'b1;
				end else if (do_read && !do_write) begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule

// >>> core/radio_state_rx_fifo_control.sv
// Radio operating-state controller with receive byte FIFO
//
// Overview of operation
// - Crystal automatic unless force-on bit set
// - Crystal-off and power-down strobes accepted only idle
// - Crystal stops on chip-select high, restarts low
// - Sleep disables core regulator until chip-select low
// - Receive strobe moves idle to receive directly
// - Manual calibrate strobe plus three auto-calibration choices
// - Idle strobe forces idle, skips auto calibration
// - After packet, exit setting picks idle or receive
// - Early termination only if the first carrier sample shows no carrier
// - OOK no-carrier valid after eight symbols
// - Early termination always returns to idle
// - Idle to receive 1953 cycles plus calibration
// - Receive to idle 2 cycles plus calibration
// - Charge pump off: 3764 or 4073 cycles
// - Charge pump on: 18506 or 18815 cycles
// - 64-byte receive FIFO with overflow detection
// - Status byte and count field report fill
// - Threshold is four times field plus four
// - Threshold signal high at or above threshold
// - Overflow flag holds until FIFO flushed
`timescale 1ns/10ps
module radio_state_rx_fifo_control
	import radio_ctrl_pkg::*;
#(
	parameter logic [15:0] CAL_CP_SHORT_CYCLES = 16'h484A,
	parameter logic [15:0] CAL_CP_LONG_CYCLES = 16'h497F
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic CHIP_SELECT_LOW,
	input wire logic RECEIVE_STROBE,
	input wire logic IDLE_STROBE,
	input wire logic CALIBRATE_STROBE,
	input wire logic CRYSTAL_OFF_STROBE,
	input wire logic POWER_DOWN_STROBE,
	input wire logic RESET_STROBE,
	input wire logic FLUSH_STROBE,
	input wire logic XOSC_FORCE_ON,
	input wire logic [1:0] AUTO_CALIBRATION_SELECT,
	input wire logic [1:0] RECEIVE_EXIT_SELECT,
	input wire logic EARLY_RECEIVE_TERMINATION,
	input wire logic OOK_MODE,
	input wire logic [1:0] CHARGE_PUMP_CAL_SELECT,
	input wire logic [7:0] TEST_CFG_ZERO,
	input wire logic [3:0] FIFO_THRESHOLD_FIELD,
	input wire logic PACKET_DONE,
	input wire logic CARRIER_SAMPLE_VALID,
	input wire logic CARRIER_SENSE,
	input wire logic LINK_CLK,
	input wire logic LINK_DATA,
	input wire logic FIFO_READ,
	output logic [7:0] FIFO_DATA,
	output logic FIFO_DATA_VALID,
	output logic CRYSTAL_ENABLE,
	output logic REGULATOR_ENABLE,
	output logic CHIP_READY_N,
	output logic CALIBRATING,
	output logic RECEIVING,
	output logic [7:0] STATUS_BYTE,
	output logic [7:0] RECEIVE_COUNT_REG,
	output logic FIFO_THRESHOLD,
	output logic RX_OVERFLOW
);

	state_type state;
	state_type next_state;
	logic [COUNT_W-1:0] wait_count;
	logic [COUNT_W-1:0] next_wait;
	logic cs_s1, cs_s2, cs_s3, cs_low;
	logic lk_s1, lk_s2, lk_s3, lk_level;
	logic dt_s1, dt_s2, dt_s3;
	logic link_rise;
	logic cs_released;
	logic [1:0] auto_exit_turns;
	logic [3:0] symbol_count;
	logic first_sample_seen;
	logic [7:0] shift_reg;
	logic [2:0] bit_count;
	logic push_valid;
	logic [7:0] push_data;
	logic push_ready;
	logic overflow;
	logic pop_valid;
	logic [7:0] pop_data;
	logic [RX_COUNT_W-1:0] fill;
	logic auto_exit;
	logic exit_cal;
	logic [COUNT_W-1:0] cal_time;

	// Calibration length from charge-pump and test settings
	function automatic logic [COUNT_W-1:0] cal_cycles(input logic [1:0] cp_sel,
			input logic [7:0] test);
		logic long_cal;
		long_cal = test[TEST_LONG_CAL_BIT];
		if (cp_sel == CP_CAL_OFF) begin
			cal_cycles = long_cal ? CAL_NO_CP_LONG_CYCLES : CAL_NO_CP_SHORT_CYCLES;
		end else begin
			cal_cycles = long_cal ? CAL_CP_LONG_CYCLES : CAL_CP_SHORT_CYCLES;
		end
	endfunction

	function automatic logic [2:0] state_code(input state_type st);
		case (st)
			ST_IDLE: state_code = CODE_IDLE;
			ST_RX: state_code = CODE_RX;
			ST_SETTLE, ST_ENDCAL: state_code = CODE_SETTLE;
			ST_CAL: state_code = CODE_CAL;
			ST_OVERFLOW: state_code = CODE_OVERFLOW;
			default: state_code = CODE_OFF;
		endcase
	endfunction

	assign cal_time = cal_cycles(CHARGE_PUMP_CAL_SELECT, TEST_CFG_ZERO);

	// Pin synchronisers; a change counts once the second and third stages agree
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			cs_low <= 1'b0;
		end else if (CLK_EN) begin
			cs_s1 <= CHIP_SELECT_LOW;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			if (cs_s2 == cs_s3) begin
				cs_low <= !cs_s3;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lk_s1 <= 1'b0;
			lk_s2 <= 1'b0;
			lk_s3 <= 1'b0;
			lk_level <= 1'b0;
			dt_s1 <= 1'b0;
			dt_s2 <= 1'b0;
			dt_s3 <= 1'b0;
		end else if (CLK_EN) begin
			lk_s1 <= LINK_CLK;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
			dt_s1 <= LINK_DATA;
			dt_s2 <= dt_s1;
			dt_s3 <= dt_s2;
			if (lk_s2 == lk_s3) begin
				lk_level <= lk_s3;
			end
		end
	end

	assign link_rise = (lk_s2 == lk_s3) && lk_s3 && !lk_level;

	// Automatic exits from receive
	always_comb begin
		auto_exit = 1'b0;
		if (PACKET_DONE && RECEIVE_EXIT_SELECT != RXEXIT_STAY_RX) begin
			auto_exit = 1'b1;
		end
		if (EARLY_RECEIVE_TERMINATION && CARRIER_SAMPLE_VALID && !first_sample_seen &&
				(!OOK_MODE || symbol_count >= OOK_MIN_SYMBOLS) && !CARRIER_SENSE) begin
			auto_exit = 1'b1;
		end
	end

	always_comb begin
		case (AUTO_CALIBRATION_SELECT)
			AUTOCAL_RX_TO_IDLE: exit_cal = 1'b1;
			AUTOCAL_EVERY_FOURTH: exit_cal = (auto_exit_turns == 2'h3);
			default: exit_cal = 1'b0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_wait = wait_count;
		case (state)
			ST_SLEEP, ST_CRYSTAL_OFF_STATE: begin
				if (cs_released && cs_low) begin
					next_state = ST_WAKE;
					next_wait = XOSC_START_CYCLES - 16'h0001;
				end
			end
			ST_WAKE: begin
				if (wait_count == '0) begin
					next_state = ST_IDLE;
				end else begin
					next_wait = wait_count - 16'h0001;
				end
			end
			ST_IDLE: begin
				if (RECEIVE_STROBE) begin
					next_state = ST_SETTLE;
					next_wait = IDLE_TO_RX_CYCLES - 16'h0001;
					if (AUTO_CALIBRATION_SELECT == AUTOCAL_IDLE_TO_RX) begin
						next_wait = IDLE_TO_RX_CYCLES + cal_time - 16'h0001;
					end
				end else if (CALIBRATE_STROBE) begin
					next_state = ST_CAL;
					next_wait = MANUAL_CAL_BASE_CYCLES + cal_time - 16'h0001;
				end else if (CRYSTAL_OFF_STROBE) begin
					next_state = ST_CRYSTAL_OFF_STATE;
				end else if (POWER_DOWN_STROBE) begin
					next_state = ST_SLEEP;
				end
			end
			ST_CAL, ST_ENDCAL: begin
				if (wait_count == '0) begin
					next_state = ST_IDLE;
				end else begin
					next_wait = wait_count - 16'h0001;
				end
			end
			ST_SETTLE: begin
				if (wait_count == '0) begin
					next_state = ST_RX;
				end else begin
					next_wait = wait_count - 16'h0001;
				end
			end
			ST_RX: begin
				if (overflow || (push_valid && !push_ready)) begin
					next_state = ST_OVERFLOW;
				end else if (auto_exit) begin
					next_state = ST_ENDCAL;
					next_wait = exit_cal ? RX_TO_IDLE_CYCLES + cal_time - 16'h0001
						: RX_TO_IDLE_CYCLES - 16'h0001;
				end
			end
			ST_OVERFLOW: begin
				if (FLUSH_STROBE) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Idle and reset strobes override everything, so no exit calibration
		if (IDLE_STROBE || RESET_STROBE) begin
			next_state = ST_IDLE;
			next_wait = '0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			wait_count <= '0;
		end else if (CLK_EN) begin
			state <= next_state;
			wait_count <= next_wait;
		end
	end

	// Chip-select must rise before a low level can wake the chip
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_released <= 1'b0;
		end else if (CLK_EN) begin
			if (state != ST_SLEEP && state != ST_CRYSTAL_OFF_STATE) begin
				cs_released <= 1'b0;
			end else if (!cs_low) begin
				cs_released <= 1'b1;
			end
		end
	end

	// Every fourth automatic exit; forced exits do not count
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			auto_exit_turns <= '0;
		end else if (CLK_EN) begin
			if (RESET_STROBE) begin
				auto_exit_turns <= '0;
			end else if (state == ST_RX && next_state == ST_ENDCAL) begin
				auto_exit_turns <= auto_exit_turns + 2'h1;
			end
		end
	end

	// Symbol count and first carrier sample, restarted on each receive entry
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			symbol_count <= '0;
			first_sample_seen <= 1'b0;
		end else if (CLK_EN) begin
			if (state != ST_RX) begin
				symbol_count <= '0;
				first_sample_seen <= 1'b0;
			end else begin
				if (link_rise && symbol_count < OOK_MIN_SYMBOLS) begin
					symbol_count <= symbol_count + 4'h1;
				end
				if (CARRIER_SAMPLE_VALID && (!OOK_MODE || symbol_count >= OOK_MIN_SYMBOLS)) begin
					first_sample_seen <= 1'b1;
				end
			end
		end
	end

	// Serial bits on the link, MSB first, gathered into bytes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_reg <= '0;
			bit_count <= '0;
			push_valid <= 1'b0;
			push_data <= '0;
		end else if (CLK_EN) begin
			push_valid <= 1'b0;
			if (state != ST_RX) begin
				bit_count <= '0;
			end else if (link_rise) begin
				shift_reg <= {shift_reg[6:0], dt_s3};
				bit_count <= bit_count + 3'h1;
				if (bit_count == 3'h7) begin
					push_valid <= 1'b1;
					push_data <= {shift_reg[6:0], dt_s3};
				end
			end
		end
	end

	// A byte refused by a full FIFO is lost; set wins over flush
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			overflow <= 1'b0;
		end else if (CLK_EN) begin
			if (push_valid && !push_ready) begin
				overflow <= 1'b1;
			end else if (FLUSH_STROBE || RESET_STROBE) begin
				overflow <= 1'b0;
			end
		end
	end

	rx_byte_fifo #(
		.WIDTH(RX_FIFO_WIDTH),
		.DEPTH(RX_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.clk_en(CLK_EN),
		.flush(FLUSH_STROBE || RESET_STROBE),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(FIFO_READ),
		.out_data(pop_data),
		.count(fill)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FIFO_DATA <= '0;
			FIFO_DATA_VALID <= 1'b0;
		end else if (CLK_EN) begin
			FIFO_DATA_VALID <= FIFO_READ && pop_valid;
			if (FIFO_READ && pop_valid) begin
				FIFO_DATA <= pop_data;
			end
		end
	end

	// Registered status and control outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CRYSTAL_ENABLE <= 1'b1;
			REGULATOR_ENABLE <= 1'b1;
			CHIP_READY_N <= 1'b0;
			CALIBRATING <= 1'b0;
			RECEIVING <= 1'b0;
			STATUS_BYTE <= '0;
			RECEIVE_COUNT_REG <= '0;
			FIFO_THRESHOLD <= 1'b0;
			RX_OVERFLOW <= 1'b0;
		end else if (CLK_EN) begin
			CRYSTAL_ENABLE <= XOSC_FORCE_ON ||
				!((state == ST_SLEEP || state == ST_CRYSTAL_OFF_STATE) && cs_released);
			REGULATOR_ENABLE <= !(state == ST_SLEEP && cs_released);
			CHIP_READY_N <= (state == ST_WAKE) ||
				((state == ST_SLEEP || state == ST_CRYSTAL_OFF_STATE) && cs_released);
			CALIBRATING <= (state == ST_CAL) || (state == ST_ENDCAL && wait_count > 16'h0001);
			RECEIVING <= (state == ST_RX);
			STATUS_BYTE[STATUS_READY_BIT] <= (state == ST_WAKE);
			STATUS_BYTE[STATUS_STATE_LSB +: 3] <= state_code(state);
			STATUS_BYTE[3:0] <= (fill > 7'(STATUS_FILL_MAX)) ? STATUS_FILL_MAX
				: fill[3:0];
			RECEIVE_COUNT_REG <= {overflow, fill};
			// Widen before adding, so field 15 gives 64 rather than a wrapped zero
			FIFO_THRESHOLD <= (fill >= {1'b0, FIFO_THRESHOLD_FIELD, 2'b00} + 7'h04);
			RX_OVERFLOW <= overflow;
		end
	end

endmodule

// >>> testbench/radio_ctrl_sva.sv
// Port-level assertions for the radio state controller
`timescale 1ns/10ps
module radio_ctrl_sva
	import radio_ctrl_pkg::*;
#(
	parameter logic [15:0] CAL_CP_SHORT_CYCLES = 16'h484A,
	parameter logic [15:0] CAL_CP_LONG_CYCLES = 16'h497F
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CHIP_SELECT_LOW,
	input wire logic RECEIVE_STROBE,
	input wire logic IDLE_STROBE,
	input wire logic RESET_STROBE,
	input wire logic FLUSH_STROBE,
	input wire logic XOSC_FORCE_ON,
	input wire logic [1:0] AUTO_CALIBRATION_SELECT,
	input wire logic [1:0] RECEIVE_EXIT_SELECT,
	input wire logic EARLY_RECEIVE_TERMINATION,
	input wire logic OOK_MODE,
	input wire logic [1:0] CHARGE_PUMP_CAL_SELECT,
	input wire logic [7:0] TEST_CFG_ZERO,
	input wire logic [3:0] FIFO_THRESHOLD_FIELD,
	input wire logic PACKET_DONE,
	input wire logic CARRIER_SAMPLE_VALID,
	input wire logic CARRIER_SENSE,
	input wire logic CRYSTAL_ENABLE,
	input wire logic REGULATOR_ENABLE,
	input wire logic CHIP_READY_N,
	input wire logic CALIBRATING,
	input wire logic RECEIVING,
	input wire logic [7:0] STATUS_BYTE,
	input wire logic [7:0] RECEIVE_COUNT_REG,
	input wire logic FIFO_THRESHOLD,
	input wire logic RX_OVERFLOW
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic armed, first;
	logic [15:0] cnt, exp_n, cal_t;
	logic [6:0] thr;
	logic [3:0] fill;
	wire logic idle = STATUS_BYTE[6:4] == CODE_IDLE;
	always_comb begin
		if (CHARGE_PUMP_CAL_SELECT == CP_CAL_OFF) begin
			cal_t = TEST_CFG_ZERO[TEST_LONG_CAL_BIT] ? CAL_NO_CP_LONG_CYCLES : CAL_NO_CP_SHORT_CYCLES;
		end else begin
			cal_t = TEST_CFG_ZERO[TEST_LONG_CAL_BIT] ? CAL_CP_LONG_CYCLES : CAL_CP_SHORT_CYCLES;
		end
		thr = {1'b0, FIFO_THRESHOLD_FIELD, 2'b00} + 7'h04;
		fill = RECEIVE_COUNT_REG[6:0] > 7'h0F ? STATUS_FILL_MAX : RECEIVE_COUNT_REG[3:0];
	end
	// Count from an accepted receive strobe; the outputs lag state by one cycle
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			armed <= 1'b0;
			cnt <= 16'h0000;
			exp_n <= 16'h0000;
		end else if (RECEIVE_STROBE && idle && !RECEIVING && !IDLE_STROBE && !RESET_STROBE) begin
			armed <= 1'b1;
			cnt <= 16'h0001;
			exp_n <= IDLE_TO_RX_CYCLES + 16'h0002 +
				(AUTO_CALIBRATION_SELECT == AUTOCAL_IDLE_TO_RX ? cal_t : 16'h0000);
		end else if (IDLE_STROBE || RESET_STROBE || RECEIVING) begin
			armed <= 1'b0;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			first <= 1'b0;
		end else begin
			first <= RECEIVING && (first || CARRIER_SAMPLE_VALID);
		end
	end
	sequence s_waking;
		CHIP_READY_N [*8] ##[50:75] !CHIP_READY_N;
	endsequence
	sequence s_steady;
		($stable(RECEIVE_COUNT_REG) && $stable(FIFO_THRESHOLD_FIELD)) [*3];
	endsequence
	a_force_osc_on: assert property (XOSC_FORCE_ON && $past(XOSC_FORCE_ON) &&
		$past(XOSC_FORCE_ON, 2) |-> CRYSTAL_ENABLE) else $error("crystal off while forced on");
	a_pd_after_cs: assert property ($fell(REGULATOR_ENABLE) |->
		$past(CHIP_SELECT_LOW, 3) && !RECEIVING) else $error("regulator off too early");
	a_wake_ready: assert property ($fell(CHIP_SELECT_LOW) && CHIP_READY_N |=> s_waking)
		else $error("ready after wake out of window");
	a_rx_entry_time: assert property ($rose(RECEIVING) && armed |-> cnt == exp_n)
		else $error("receive entry time wrong");
	a_idle_no_cal: assert property (RECEIVING && IDLE_STROBE && !$past(PACKET_DONE) &&
		!$past(CARRIER_SAMPLE_VALID) |=> !CALIBRATING [*2]) else $error("calibrated on forced idle");
	a_pkt_stay_rx: assert property (RECEIVING && PACKET_DONE && !CARRIER_SAMPLE_VALID &&
		RECEIVE_EXIT_SELECT == RXEXIT_STAY_RX && !IDLE_STROBE && !RESET_STROBE |=> RECEIVING [*4])
		else $error("left receive after packet");
	a_pkt_to_idle: assert property (RECEIVING && PACKET_DONE &&
		RECEIVE_EXIT_SELECT != RXEXIT_STAY_RX && AUTO_CALIBRATION_SELECT == AUTOCAL_NEVER
		|-> ##[2:5] (idle && !RECEIVING)) else $error("packet exit not idle in time");
	a_early_exit: assert property (RECEIVING && EARLY_RECEIVE_TERMINATION && !OOK_MODE &&
		CARRIER_SAMPLE_VALID && !CARRIER_SENSE && !first &&
		AUTO_CALIBRATION_SELECT == AUTOCAL_NEVER |-> ##[2:6] idle) else $error("no early exit");
	a_ovf_sticky: assert property (RX_OVERFLOW && !FLUSH_STROBE && !RESET_STROBE &&
		!$past(FLUSH_STROBE) && !$past(RESET_STROBE) |=> RX_OVERFLOW) else $error("overflow lost");
	a_fill_view: assert property (s_steady |-> FIFO_THRESHOLD == (RECEIVE_COUNT_REG[6:0] >= thr) &&
		STATUS_BYTE[3:0] == fill) else $error("fill outputs disagree");
endmodule
bind radio_state_rx_fifo_control radio_ctrl_sva #(.CAL_CP_SHORT_CYCLES(CAL_CP_SHORT_CYCLES),
	.CAL_CP_LONG_CYCLES(CAL_CP_LONG_CYCLES)) radio_ctrl_sva_i (.*);

// >>> testbench/host_model.sv
// Host microcontroller model: chip-select wake-up and receive FIFO reads
`timescale 1ns/10ps
module host_model (
	input wire logic CLK,
	input wire logic CHIP_READY_N,
	input wire logic [7:0] RECEIVE_COUNT_REG,
	input wire logic [7:0] FIFO_DATA,
	input wire logic FIFO_DATA_VALID,
	output logic CHIP_SELECT_LOW,
	output logic FIFO_READ
);
	initial begin
		CHIP_SELECT_LOW = 1'b1;
		FIFO_READ = 1'b0;
	end
	// No serial use until ready drops, bounded so a dead device cannot hang us
	task wake(output int n);
		@(posedge CLK) #1;
		CHIP_SELECT_LOW = 1'b0;
		n = 0;
		while (CHIP_READY_N !== 1'b0 && n < 500) begin
			@(posedge CLK) #1;
			n++;
		end
	endtask
	task rel();
		@(posedge CLK) #1;
		CHIP_SELECT_LOW = 1'b1;
	endtask
	task pop(output logic [7:0] d, output logic v);
		v = 1'b0;
		d = 8'h00;
		if (RECEIVE_COUNT_REG[6:0] < 7'h02) return;
		@(posedge CLK) #1;
		FIFO_READ = 1'b1;
		@(posedge CLK) #1;
		FIFO_READ = 1'b0;
		// Valid stands only for the cycle after the sampling edge; data holds until the next read
		d = FIFO_DATA;
		v = FIFO_DATA_VALID;
	endtask
endmodule

// >>> testbench/radio_state_rx_fifo_control_tb.sv
// Self-checking bench for the radio state controller and receive FIFO
`timescale 1ns/10ps
module radio_state_rx_fifo_control_tb
	import radio_ctrl_pkg::*;
();
	localparam logic [15:0] CP_SHORT = 16'h0028;
	localparam logic [15:0] CP_LONG = 16'h0032;
	logic CLK = 0, RST_N = 0, CLK_EN = 1, CALIBRATE_STROBE = 0, OOK_MODE = 0;
	logic RECEIVE_STROBE, IDLE_STROBE, CRYSTAL_OFF_STROBE, POWER_DOWN_STROBE;
	logic RESET_STROBE, FLUSH_STROBE, PACKET_DONE, CARRIER_SAMPLE_VALID;
	logic XOSC_FORCE_ON = 0, EARLY_RECEIVE_TERMINATION = 0, CARRIER_SENSE = 0;
	logic LINK_CLK = 0, LINK_DATA = 1;
	logic [1:0] AUTO_CALIBRATION_SELECT = 2'h0, RECEIVE_EXIT_SELECT = 2'h0;
	logic [1:0] CHARGE_PUMP_CAL_SELECT = 2'h0;
	logic [7:0] TEST_CFG_ZERO = 8'h09, strb = 8'h00, FIFO_DATA, STATUS_BYTE, RECEIVE_COUNT_REG;
	logic [3:0] FIFO_THRESHOLD_FIELD = 4'h0;
	logic CHIP_SELECT_LOW, FIFO_READ, FIFO_DATA_VALID, CRYSTAL_ENABLE, REGULATOR_ENABLE;
	logic CHIP_READY_N, CALIBRATING, RECEIVING, FIFO_THRESHOLD, RX_OVERFLOW, v, seen;
	logic [7:0] d;
	int err_count = 0, n_checks = 0, cycles = 0, n;
	assign {RECEIVE_STROBE, IDLE_STROBE, CRYSTAL_OFF_STROBE, POWER_DOWN_STROBE, RESET_STROBE,
		FLUSH_STROBE, PACKET_DONE, CARRIER_SAMPLE_VALID} = strb;
	// Small calibration figures keep the charge-pump cases short
	radio_state_rx_fifo_control #(.CAL_CP_SHORT_CYCLES(CP_SHORT), .CAL_CP_LONG_CYCLES(CP_LONG))
		radio_state_rx_fifo_control_i (.*);
	host_model host_model_i (.*);
	always #12.5 CLK = ~CLK;
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			summarize();
		end
	end
	task summarize();
		$display("mismatches=%0d checks=%0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task cmd(input logic [7:0] m);
		wt(1);
		strb = m;
		wt(1);
		strb = 8'h00;
	endtask
	task go_rx(output int n);
		cmd(8'h80);
		n = 0;
		while (RECEIVING !== 1'b1 && n < 30000) begin
			wt(1);
			n++;
		end
	endtask
	task watch(input logic [7:0] m, output logic s);
		cmd(m);
		s = 1'b0;
		repeat (80) begin
			wt(1);
			if (CALIBRATING === 1'b1) s = 1'b1;
		end
	endtask
	// Link clock stands still between bytes; data then shows the inverse of the last bit
	task send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			LINK_DATA = b[i];
			#100 LINK_CLK = 1'b1;
			#100 LINK_CLK = 1'b0;
		end
		LINK_DATA = ~b[0];
	endtask
	task t_entry();
		check({CRYSTAL_ENABLE, REGULATOR_ENABLE, RECEIVING, RX_OVERFLOW}, 4'hC);
		// A strobe while the clock enable is low must not be taken
		CLK_EN = 1'b0;
		cmd(8'h80);
		wt(4);
		CLK_EN = 1'b1;
		check({RECEIVING, STATUS_BYTE[6:4]}, {1'b0, CODE_IDLE});
		go_rx(n);
		check(16'(n), IDLE_TO_RX_CYCLES + 16'h0001);
		cmd(8'h02);
		wt(6);
		check({RECEIVING, STATUS_BYTE[6:4]}, {1'b0, CODE_IDLE});
	endtask
	task t_early();
		RECEIVE_EXIT_SELECT = RXEXIT_STAY_RX;
		EARLY_RECEIVE_TERMINATION = 1'b1;
		go_rx(n);
		CARRIER_SENSE = 1'b1;
		cmd(8'h01);
		CARRIER_SENSE = 1'b0;
		cmd(8'h01);
		cmd(8'h02);
		wt(6);
		check(RECEIVING, 1'b1);
		cmd(8'h40);
		wt(4);
		go_rx(n);
		cmd(8'h01);
		wt(6);
		check({RECEIVING, STATUS_BYTE[6:4]}, {1'b0, CODE_IDLE});
		// On-off keying: no-carrier sample ignored until eight symbols seen
		OOK_MODE = 1'b1;
		go_rx(n);
		cmd(8'h01);
		wt(6);
		check(RECEIVING, 1'b1);
		send(8'h00);
		cmd(8'h01);
		wt(6);
		check({RECEIVING, STATUS_BYTE[6:4]}, {1'b0, CODE_IDLE});
		OOK_MODE = 1'b0;
		cmd(8'h04);
		wt(4);
		EARLY_RECEIVE_TERMINATION = 1'b0;
		RECEIVE_EXIT_SELECT = RXEXIT_IDLE;
	endtask
	task t_power();
		for (int i = 0; i < 2; i++) begin
			XOSC_FORCE_ON = i[0];
			cmd(i[0] ? 8'h20 : 8'h10);
			wt(12);
			check({CRYSTAL_ENABLE, REGULATOR_ENABLE, CHIP_READY_N}, {i[0], i[0], 1'b1});
			host_model_i.wake(n);
			check({CRYSTAL_ENABLE, REGULATOR_ENABLE, CHIP_READY_N, STATUS_BYTE[6:4]}, {3'h6, CODE_IDLE});
			host_model_i.rel();
			wt(6);
		end
		XOSC_FORCE_ON = 1'b0;
	endtask
	task t_cal();
		AUTO_CALIBRATION_SELECT = AUTOCAL_IDLE_TO_RX;
		go_rx(n);
		check(16'(n), IDLE_TO_RX_CYCLES + CAL_NO_CP_SHORT_CYCLES + 16'h0001);
		cmd(8'h40);
		wt(4);
		TEST_CFG_ZERO = 8'h0B;
		CHARGE_PUMP_CAL_SELECT = 2'h2;
		go_rx(n);
		check(16'(n), IDLE_TO_RX_CYCLES + CP_LONG + 16'h0001);
		AUTO_CALIBRATION_SELECT = AUTOCAL_RX_TO_IDLE;
		watch(8'h40, seen);
		check(seen, 1'b0);
		go_rx(n);
		watch(8'h02, seen);
		check({seen, RECEIVING}, 2'h2);
		cmd(8'h08);
		wt(4);
		AUTO_CALIBRATION_SELECT = AUTOCAL_EVERY_FOURTH;
		for (int k = 1; k <= 4; k++) begin
			go_rx(n);
			watch(8'h02, seen);
			check(seen, k == 4);
		end
		// Manual calibration from idle, timed by the calibrating output
		wt(1);
		CALIBRATE_STROBE = 1'b1;
		wt(1);
		CALIBRATE_STROBE = 1'b0;
		n = 0;
		wt(1);
		while (CALIBRATING === 1'b1 && n < 1000) begin
			wt(1);
			n++;
		end
		check(16'(n), MANUAL_CAL_BASE_CYCLES + CP_LONG);
		AUTO_CALIBRATION_SELECT = AUTOCAL_NEVER;
	endtask
	task t_fifo();
		RECEIVE_EXIT_SELECT = RXEXIT_STAY_RX;
		go_rx(n);
		for (int k = 0; k < 3; k++) send(8'(k) ^ 8'hA5);
		wt(8);
		check({FIFO_THRESHOLD, RECEIVE_COUNT_REG, STATUS_BYTE[3:0]}, {1'b0, 8'h03, 4'h3});
		send(8'h03 ^ 8'hA5);
		wt(8);
		check(FIFO_THRESHOLD, 1'b1);
		cmd(8'h10);
		wt(8);
		check({RECEIVING, REGULATOR_ENABLE}, 2'h3);
		for (int k = 4; k < 64; k++) send(8'(k) ^ 8'hA5);
		FIFO_THRESHOLD_FIELD = 4'hF;
		wt(8);
		check({FIFO_THRESHOLD, RX_OVERFLOW, RECEIVE_COUNT_REG, STATUS_BYTE[3:0]},
			{2'h2, 8'h40, STATUS_FILL_MAX});
		host_model_i.pop(d, v);
		wt(4);
		check({v, d, FIFO_THRESHOLD}, {1'b1, 8'hA5, 1'b0});
		send(8'h5A);
		send(8'h5A);
		wt(8);
		check({RX_OVERFLOW, RECEIVE_COUNT_REG}, {1'b1, 8'hC0});
		cmd(8'h40);
		wt(4);
		check(RX_OVERFLOW, 1'b1);
		cmd(8'h04);
		wt(4);
		check({RX_OVERFLOW, RECEIVE_COUNT_REG}, 9'h000);
	endtask
	initial begin
		repeat (2) @(posedge CLK);
		#1 RST_N = 1'b1;
		wt(2);
		t_entry();
		t_early();
		t_power();
		t_cal();
		t_fifo();
		summarize();
	end
endmodule
